// ---- design/abs_reader_consts.svh ----
// Constants of the absolute position reader: register offsets, field
// positions, reset values and transfer counts.
// Assumes inclusion by bare name from the design files.
`ifndef ABS_READER_CONSTS_SVH
`define ABS_READER_CONSTS_SVH
`define OFS_CONTROL     12'h000
`define OFS_STATUS      12'h004
`define OFS_IRQ_STATUS  12'h008
`define OFS_IRQ_ENABLE  12'h00C
`define OFS_IRQ_CLEAR   12'h010
`define OFS_SCALE       12'h014
`define OFS_POS_BASE    12'h020
`define BIT_ACTIVATE    0
`define BIT_CHANNEL     1
`define BIT_COMPLETE    0
`define BIT_ABNORMAL    1
`define BIT_BUSY        2
`define IRQ_DONE        0
`define IRQ_ABORT       1
`define POS_BITS        32
`define CHECK_BITS      6
`define TOTAL_STEPS     19
`define SCALE_RESET     16'h0001
`define POS_RESET       32'h0000_0000
`endif

// ---- design/abs_reader_pkg.sv ----
// Types shared by the absolute position reader.
// Assumes the constants header is compiled alongside.
package abs_reader_pkg;
  typedef enum logic [2:0] {
    st_idle    = 3'b000,
    st_request = 3'b001,
    st_release = 3'b010,
    st_store   = 3'b011,
    st_held    = 3'b100
  } read_state_t;
endpackage

// ---- design/pin_sync.sv ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clock.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] synced
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.stage1 = pins;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign synced = state.stage2;
endmodule

// ---- design/servo_absolute_position_reader.sv ----
// Absolute position reader: handshaked two-bit transfer from a servo
// amplifier, conversion to pulses, storage in per-channel positions.
// Assumes an APB master on clock and amplifier pins asynchronous to it.
`timescale 1ns/1ps
`include "abs_reader_consts.svh"

//////////////////////////////////////////////////////////////////////////
module servo_absolute_position_reader #(
  parameter int CHANNELS = 4
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        data_bit0,
  input  wire logic        data_bit1,
  input  wire logic        send_ready,
  output logic             servo_on_output,
  output logic             transfer_mode,
  output logic             data_request,
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////
  typedef struct packed {
    abs_reader_pkg::read_state_t fsm;
    logic                  activate;
    logic [1:0]            channel;
    logic [15:0]           scale;
    logic [4:0]            steps;
    logic [37:0]           shift;
    logic                  execution_complete_flag;
    logic                  abnormal_end_flag;
    logic [1:0]            irq_status;
    logic [1:0]            irq_enable;
    logic                  servo_on;
    logic                  mode;
    logic                  request;
    logic [CHANNELS*32-1:0] position;
    logic [31:0]           rdata;
  } reader_state_t;

  reader_state_t state;
  reader_state_t next_state;
  logic [2:0]    amp_in;
  logic          in_bit0;
  logic          in_bit1;
  logic          in_ready;
  logic          wr;
  logic          rd;
  logic [31:0]   raw_pos;
  logic [31:0]   pulses;
  logic [1:0]    irq_set;
  logic          ack;

  pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .clock  (clock),
    .rst    (rst),
    .pins   ({send_ready, data_bit1, data_bit0}),
    .synced (amp_in)
  );

  assign in_bit0  = amp_in[0];
  assign in_bit1  = amp_in[1];
  assign in_ready = amp_in[2];
  // A write lands only at the edge that completes the access, so the
  // wait state never applies it twice.
  assign wr = psel && penable && pwrite && ack;
  assign rd = psel && penable && !pwrite;

  // The amplifier sends the low bits first; the six check bits trail
  // the position and are kept only for the shift length.
  assign raw_pos = state.shift[31:0];
  assign pulses = 32'(raw_pos * {16'h0000, state.scale});

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    irq_set = 2'b00;
    if (!state.activate) begin
      next_state.servo_on = 1'b0;
      next_state.mode = 1'b0;
      next_state.request = 1'b0;
      next_state.fsm = abs_reader_pkg::st_idle;
      if (state.fsm != abs_reader_pkg::st_idle &&
          state.fsm != abs_reader_pkg::st_held) begin
        next_state.abnormal_end_flag = 1'b1;
        irq_set[`IRQ_ABORT] = 1'b1;
      end
    end else begin
      case (state.fsm)
        abs_reader_pkg::st_idle: begin
          next_state.servo_on = 1'b1;
          next_state.mode = 1'b1;
          next_state.steps = 5'h00;
          next_state.execution_complete_flag = 1'b0;
          next_state.abnormal_end_flag = 1'b0;
          next_state.fsm = abs_reader_pkg::st_request;
        end
        abs_reader_pkg::st_request: begin
          next_state.request = 1'b1;
          if (state.request && in_ready) begin
            next_state.shift = {in_bit1, in_bit0, state.shift[37:2]};
            next_state.request = 1'b0;
            next_state.steps = 5'(state.steps + 5'h01);
            next_state.fsm = abs_reader_pkg::st_release;
          end
        end
        abs_reader_pkg::st_release: begin
          if (!in_ready) begin
            if (state.steps == 5'(`TOTAL_STEPS)) begin
              next_state.fsm = abs_reader_pkg::st_store;
            end else begin
              next_state.fsm = abs_reader_pkg::st_request;
            end
          end
        end
        abs_reader_pkg::st_store: begin
          next_state.position[state.channel*32 +: 32] = pulses;
          next_state.execution_complete_flag = 1'b1;
          irq_set[`IRQ_DONE] = 1'b1;
          next_state.mode = 1'b0;
          next_state.fsm = abs_reader_pkg::st_held;
        end
        abs_reader_pkg::st_held: begin
          next_state.servo_on = 1'b1;
        end
        default: begin
          next_state.fsm = abs_reader_pkg::st_idle;
        end
      endcase
    end

    next_state.rdata = 32'h0000_0000;
    if (wr) begin
      if (paddr == `OFS_CONTROL) begin
        next_state.activate = pwdata[`BIT_ACTIVATE];
        next_state.channel = pwdata[`BIT_CHANNEL +: 2];
      end else if (paddr == `OFS_IRQ_ENABLE) begin
        next_state.irq_enable = pwdata[1:0];
      end else if (paddr == `OFS_IRQ_CLEAR) begin
        next_state.irq_status = state.irq_status & ~pwdata[1:0];
      end else if (paddr == `OFS_SCALE) begin
        next_state.scale = pwdata[15:0];
      end else if (paddr >= `OFS_POS_BASE &&
                   paddr < 12'(`OFS_POS_BASE + 4 * CHANNELS)) begin
        next_state.position[paddr[3:2]*32 +: 32] = pwdata;
      end
    end else if (rd) begin
      if (paddr == `OFS_CONTROL) begin
        next_state.rdata = {29'h0, state.channel, state.activate};
      end else if (paddr == `OFS_STATUS) begin
        next_state.rdata = {29'h0, state.fsm != abs_reader_pkg::st_idle &&
          state.fsm != abs_reader_pkg::st_held,
          state.abnormal_end_flag, state.execution_complete_flag};
      end else if (paddr == `OFS_IRQ_STATUS) begin
        next_state.rdata = {30'h0, state.irq_status};
      end else if (paddr == `OFS_IRQ_ENABLE) begin
        next_state.rdata = {30'h0, state.irq_enable};
      end else if (paddr == `OFS_SCALE) begin
        next_state.rdata = {16'h0000, state.scale};
      end else if (paddr >= `OFS_POS_BASE &&
                   paddr < 12'(`OFS_POS_BASE + 4 * CHANNELS)) begin
        next_state.rdata = state.position[paddr[3:2]*32 +: 32];
      end
    end
    // Set wins over a clear in the same cycle.
    next_state.irq_status = next_state.irq_status | irq_set;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '0;
      state.scale <= `SCALE_RESET;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registered read data is captured in the first access cycle and returned in the next, so
  // every access takes one wait state.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= psel && penable && !ack;
    end
  end

  assign pready  = ack;
  assign pslverr = 1'b0;
  assign prdata  = state.rdata;
  assign servo_on_output = state.servo_on;
  assign transfer_mode   = state.mode;
  assign data_request    = state.request;
  assign irq = |(state.irq_status & state.irq_enable);

  //////////////////////////////////////////////////////////////////////
  servo_mode_a: assert property (@(posedge clock) disable iff (rst)
    data_request |-> servo_on_output && transfer_mode)
    else $error("Request without servo on and mode.");

  servo_drop_a: assert property (@(posedge clock) disable iff (rst)
    !state.activate |=> !servo_on_output)
    else $error("Servo on stayed after deactivation.");

  abort_read_a: assert property (@(posedge clock) disable iff (rst)
    !state.activate |=> !data_request)
    else $error("Request continued after abort.");

  logic execution_complete_flag_q;
  assign execution_complete_flag_q = state.execution_complete_flag;

  complete_flag_a: assert property (@(posedge clock) disable iff (rst)
    state.fsm == abs_reader_pkg::st_store && state.activate
      |=> execution_complete_flag_q)
    else $error("Complete flag not set after store.");

  mode_end_a: assert property (@(posedge clock) disable iff (rst)
    state.fsm == abs_reader_pkg::st_held && state.activate
      |-> servo_on_output && !transfer_mode)
    else $error("Mode or servo wrong after completion.");

  step_count_a: assert property (@(posedge clock) disable iff (rst)
    state.fsm == abs_reader_pkg::st_store |-> state.steps == 5'(`TOTAL_STEPS))
    else $error("Store reached with wrong step count.");

  request_release_a: assert property (@(posedge clock)
    disable iff (rst)
    data_request && in_ready && state.activate |=> !data_request)
    else $error("Request not released after ready.");

  store_value_a: assert property (@(posedge clock) disable iff (rst)
    state.fsm == abs_reader_pkg::st_store && state.activate
      |=> state.position[state.channel*32 +: 32] == $past(pulses))
    else $error("Stored position differs from converted value.");

  // The checks below cover the handshake order and the flags that
  // software relies on; none of them watch the bench's own signals.
  request_order_a: assert property (@(posedge clock)
    disable iff (rst)
    $rose(data_request) |-> $past(servo_on_output) && $past(transfer_mode))
    else $error("Request rose before servo on and mode.");

  shift_pair_a: assert property (@(posedge clock) disable iff (rst)
    state.fsm == abs_reader_pkg::st_request && state.request &&
      in_ready && state.activate
      |=> state.shift[37:36] == $past({in_bit1, in_bit0}))
    else $error("Bit pair not shifted in on ready.");

  abort_flag_a: assert property (@(posedge clock) disable iff (rst)
    state.fsm == abs_reader_pkg::st_request && !state.activate
      |=> state.abnormal_end_flag)
    else $error("Abort did not set the abnormal flag.");

  no_error_a: assert property (@(posedge clock) disable iff (rst)
    state.activate |=> !$rose(state.abnormal_end_flag))
    else $error("Error flagged while still activated.");

  step_bound_a: assert property (@(posedge clock) disable iff (rst)
    state.steps <= 5'(`TOTAL_STEPS))
    else $error("Step count ran past the transfer length.");

  complete_source_a: assert property (@(posedge clock)
    disable iff (rst)
    $rose(state.execution_complete_flag)
      |-> $past(state.fsm) == abs_reader_pkg::st_store)
    else $error("Complete flag rose outside the store step.");
endmodule

// ---- dv/servo_absolute_position_reader_tb_top.sv ----
// Testbench: APB register tests and position reads against a model.
// Assumes the reader, its constants header and the amplifier model.
`timescale 1ns/1ps
`include "abs_reader_consts.svh"
module servo_absolute_position_reader_tb_top;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        data_bit0, data_bit1, send_ready, req_d;
  logic        servo_on_output, transfer_mode, data_request;
  logic [37:0] word;
  logic [15:0] delay;
  int          mismatches, comparisons, requests, n;
  servo_absolute_position_reader u_servo_absolute_position_reader (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .data_bit0, .data_bit1, .send_ready,
    .servo_on_output, .transfer_mode, .data_request, .irq);
  servo_amp_model u_servo_amp_model (
    .clock, .servo_on_output, .transfer_mode, .data_request, .word,
    .delay, .data_bit0, .data_bit1, .send_ready);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    req_d <= data_request;
    if (data_request && !req_d) requests++;
  end
  //////////////////////////////////////////////////////////////////////
  task test_done();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task hang();
    mismatches++;
    $display("unexpected at %0t: wait ran out", $time);
    test_done();
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) hang();
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task wait_done();
    for (n = 0; n < 300; n++) begin
      apb(1'b0, `OFS_STATUS, 32'h0);
      if (rd[`BIT_COMPLETE] === 1'b1) break;
    end
    if (n == 300) hang();
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {mismatches, comparisons, requests} = 0;
    word  = 38'h2A_0012_3456;
    delay = 16'h0002;
    rst   = 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    check({29'h0, servo_on_output, transfer_mode, irq}, 32'h0);
    apb(1'b0, `OFS_SCALE, 32'h0);
    check(rd, 32'h1);
    for (int c = 0; c < 4; c++) begin
      apb(1'b0, `OFS_POS_BASE + 12'(4 * c), 32'h0);
      check(rd, `POS_RESET);
    end
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    apb(1'b0, 12'h0FC, 32'h0);
    check(rd, 32'h0);
    check({31'h0, pslverr}, 32'h0);
    $display("test reset values done");
    apb(1'b1, `OFS_SCALE, 32'h3);
    apb(1'b1, `OFS_IRQ_ENABLE, 32'h1);
    apb(1'b1, `OFS_CONTROL, 32'h5);
    for (n = 0; n < 100 && transfer_mode !== 1'b1; n++) @(posedge clock);
    if (n == 100) hang();
    check({31'h0, servo_on_output}, 32'h1);
    check(32'(requests), 32'h0);
    wait_done();
    check(32'(requests), `TOTAL_STEPS);
    apb(1'b0, `OFS_POS_BASE + 12'h008, 32'h0);
    check(rd, word[31:0] * 32'h3);
    apb(1'b0, `OFS_POS_BASE, 32'h0);
    check(rd, 32'h0);
    check({30'h0, servo_on_output, transfer_mode}, 32'h2);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h1);
    @(negedge clock);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, `OFS_CONTROL, 32'h0);
    repeat (4) @(posedge clock);
    check({31'h0, servo_on_output}, 32'h0);
    $display("test full read done");
    // The model never answers, so the reader must sit busy and quiet.
    delay    = 16'hFFFF;
    requests = 0;
    apb(1'b1, `OFS_CONTROL, 32'h1);
    repeat (200) @(posedge clock);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check({31'h0, rd[`BIT_ABNORMAL]}, 32'h0);
    check({31'h0, rd[`BIT_BUSY]}, 32'h1);
    apb(1'b1, `OFS_CONTROL, 32'h0);
    delay = 16'h0002;
    repeat (60) @(posedge clock);
    check(32'(requests), 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check({31'h0, rd[`BIT_ABNORMAL]}, 32'h1);
    apb(1'b0, `OFS_POS_BASE, 32'h0);
    check(rd, 32'h0);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, `OFS_IRQ_ENABLE, 32'h3);
    @(negedge clock);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h2);
    @(negedge clock);
    check({31'h0, irq}, 32'h0);
    $display("test stall and abort done");
    test_done();
  end
endmodule

// ---- dv/servo_amp_model.sv ----
// Behavioural servo amplifier answering the two-bit position handshake.
// Assumes the reader's pins and the reader's clock for pacing.
`timescale 1ns/1ps
module servo_amp_model (
  input  wire logic        clock,
  input  wire logic        servo_on_output,
  input  wire logic        transfer_mode,
  input  wire logic        data_request,
  input  wire logic [37:0] word,
  input  wire logic [15:0] delay,
  output logic             data_bit0,
  output logic             data_bit1,
  output logic             send_ready
);
  logic [5:0]  step;
  logic [15:0] wait_cnt;
  initial begin
    {data_bit1, data_bit0, send_ready} = 3'h0;
  end
  // ready paced, two bits a step
  always @(posedge clock) begin
    if (!transfer_mode || !servo_on_output) begin
      step       <= 6'h00;
      wait_cnt   <= 16'h0000;
      send_ready <= 1'b0;
    end else if (data_request && !send_ready) begin
      if (wait_cnt >= delay) begin
        {data_bit1, data_bit0} <= word[{step, 1'b0} +: 2];
        send_ready             <= 1'b1;
      end
      wait_cnt <= wait_cnt + 16'h0001;
    end else if (!data_request && send_ready) begin
      // Released lines show the inverse so stale bits never look valid.
      {data_bit1, data_bit0} <= ~{data_bit1, data_bit0};
      send_ready             <= 1'b0;
      step                   <= step + 6'h01;
      wait_cnt               <= 16'h0000;
    end
  end
endmodule
